// >>> core/tmr_pkg.sv
// Shared constants and types for the timer output and clear control block
package tmr_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] OFF_RUN_CTRL = 5'h00;
  localparam logic [4:0] OFF_MODE_CTRL = 5'h04;
  localparam logic [4:0] OFF_CMP_A = 5'h08;
  localparam logic [4:0] OFF_CMP_P = 5'h0c;
  localparam logic [4:0] OFF_COUNT = 5'h10;

  // ---------------------------------------------------------------
  // Modes and pin functions
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_CMP = 2'h0,
    MODE_CAP = 2'h1,
    MODE_PWM = 2'h2,
    MODE_TMR = 2'h3
  } mode_t;

  localparam logic [1:0] FN_HOLD = 2'h0;
  localparam logic [1:0] FN_LOW = 2'h1;
  localparam logic [1:0] FN_HIGH = 2'h2;
  localparam logic [1:0] FN_TOGGLE = 2'h3;
  localparam logic [1:0] FN_PWM = 2'h2;
  localparam logic [1:0] FN_PULSE = 2'h3;

  typedef struct packed {
    mode_t mode;
    logic [1:0] pin_func;
    logic output_initial_level_select;
    logic output_invert;
    logic period_duty_swap;
    logic clear_source_select;
  } mode_ctrl_t;

  // ---------------------------------------------------------------
  // Reset values and bus answers
  // ---------------------------------------------------------------
  localparam logic [7:0] MODE_CTRL_RST = 8'h00;
  localparam logic [15:0] CMP_A_RST = 16'h0000;
  localparam logic [7:0] CMP_P_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> core/timer_output_and_clear_control.sv
// Timer output level, inversion, PWM period/duty and counter clear logic
`timescale 1ns/1ps
// Operation
// RL1 - Compare mode: pin starts at initial-level bit
// RL2 - PWM/pulse: initial-level bit sets active level
// RL3 - Invert bit complements pin level
// RL4 - Timer mode: level and invert bits ignored
// RL5 - Swap bit exchanges PWM period and duty sources
// RL6 - Clear select 1: A match clears counter
// RL7 - Clear select 0: P match or overflow clears
// RL8 - Overflow clears only when compare P zero
// RL9 - PWM, pulse, capture ignore clear select
// RL10 - Mode field: 00 cmp,01 cap,10 pwm,11 timer
// RL11 - Counter-on rise restores compare initial level
// RL12 - P compares upper byte; A all bits
// RL13 - Inversion applied after level selection
// RL14 - Control bits reset to zero
module timer_output_and_clear_control #(
  parameter int CNT_W = 16,
  parameter int P_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Timer output pin
  output logic timer_output_pin_o,
  output logic timer_output_pin_oe_n
);
  // ---------------------------------------------------------------
  // Register file and bus slave
  // ---------------------------------------------------------------
  tmr_pkg::mode_ctrl_t ctl_q, ctl_d;
  logic counter_on_q, counter_on_d;
  logic [CNT_W-1:0] compare_a_value_q, compare_a_value_d;
  logic [P_W-1:0] compare_p_value_q, compare_p_value_d;
  logic [4:0] awaddr_q, awaddr_d;
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [CNT_W-1:0] cnt_q;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_comb begin
    ctl_d = ctl_q;
    counter_on_d = counter_on_q;
    compare_a_value_d = compare_a_value_q;
    compare_p_value_d = compare_p_value_q;
    awaddr_d = awaddr_q;
    aw_held_d = aw_held_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    w_held_d = w_held_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_d = s_axi_awaddr;
      aw_held_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
      w_held_d = 1'b1;
    end
    // Commit only once both halves are in, so address and data may come in any order
    if (aw_held_q && w_held_q) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = tmr_pkg::RESP_OKAY;
      unique case ({awaddr_q[4:2], 2'b00})
        tmr_pkg::OFF_RUN_CTRL: if (wstrb_q[0]) counter_on_d = wdata_q[0];
        tmr_pkg::OFF_MODE_CTRL: if (wstrb_q[0]) ctl_d = wdata_q[7:0];
        tmr_pkg::OFF_CMP_A: begin
          if (wstrb_q[0]) compare_a_value_d[7:0] = wdata_q[7:0];
          if (wstrb_q[1]) compare_a_value_d[15:8] = wdata_q[15:8];
        end
        tmr_pkg::OFF_CMP_P: if (wstrb_q[0]) compare_p_value_d = wdata_q[7:0];
        tmr_pkg::OFF_COUNT: bresp_d = tmr_pkg::RESP_SLVERR;
        default: bresp_d = tmr_pkg::RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = tmr_pkg::RESP_OKAY;
      rdata_d = 32'h0000_0000;
      unique case ({s_axi_araddr[4:2], 2'b00})
        tmr_pkg::OFF_RUN_CTRL: rdata_d[0] = counter_on_q;
        tmr_pkg::OFF_MODE_CTRL: rdata_d[7:0] = ctl_q;
        tmr_pkg::OFF_CMP_A: rdata_d[15:0] = compare_a_value_q;
        tmr_pkg::OFF_CMP_P: rdata_d[7:0] = compare_p_value_q;
        tmr_pkg::OFF_COUNT: rdata_d[15:0] = cnt_q;
        default: rresp_d = tmr_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_q <= tmr_pkg::MODE_CTRL_RST; // see RL14
      counter_on_q <= 1'b0;
      compare_a_value_q <= tmr_pkg::CMP_A_RST;
      compare_p_value_q <= tmr_pkg::CMP_P_RST;
      awaddr_q <= 5'h00;
      aw_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= tmr_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= tmr_pkg::RESP_OKAY;
    end else begin
      ctl_q <= ctl_d;
      counter_on_q <= counter_on_d;
      compare_a_value_q <= compare_a_value_d;
      compare_p_value_q <= compare_p_value_d;
      awaddr_q <= awaddr_d;
      aw_held_q <= aw_held_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      w_held_q <= w_held_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ---------------------------------------------------------------
  // Counter and clear source
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] cnt_d;
  logic on_prev_q, on_rise, a_hit, p_hit, ovf_hit, p_end, clr_now;

  assign on_rise = counter_on_q && !on_prev_q;
  assign a_hit = cnt_q == compare_a_value_q; // see RL12
  assign p_hit = (compare_p_value_q != '0) &&
                 (cnt_q == {compare_p_value_q, {(CNT_W-P_W){1'b1}}}); // see RL12
  // Overflow only ends the period when no P value shortens it
  assign ovf_hit = (compare_p_value_q == '0) && (cnt_q == '1); // see RL8
  assign p_end = p_hit || ovf_hit;

  always_comb begin
    unique case (ctl_q.mode) // see RL10
      tmr_pkg::MODE_PWM: clr_now = ctl_q.period_duty_swap ? a_hit : p_end; // see RL5 RL9
      tmr_pkg::MODE_CAP: clr_now = p_end; // see RL9
      tmr_pkg::MODE_CMP, tmr_pkg::MODE_TMR:
        clr_now = ctl_q.clear_source_select ? a_hit : p_end; // see RL6 RL7
    endcase
    cnt_d = cnt_q;
    if (on_rise) begin
      cnt_d = '0;
    end else if (counter_on_q) begin
      cnt_d = clr_now ? '0 : cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= tmr_pkg::COUNT_RST;
      on_prev_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      on_prev_q <= counter_on_q;
    end
  end

  // ---------------------------------------------------------------
  // Output level
  // ---------------------------------------------------------------
  logic level_q, level_d, pulse_q, pulse_d, duty_act, duty_end, active, raw, drive;
  logic pin_q, pin_d, oe_n_q, oe_n_d;

  assign timer_output_pin_o = pin_q;
  assign timer_output_pin_oe_n = oe_n_q;

  always_comb begin
    // Swap picks which compare value shapes the duty
    duty_act = ctl_q.period_duty_swap ? (cnt_q[CNT_W-1:CNT_W-P_W] < compare_p_value_q)
                                      : (cnt_q < compare_a_value_q); // see RL5
    duty_end = ctl_q.period_duty_swap ? p_hit : a_hit;
    level_d = level_q;
    if (on_rise) begin
      level_d = ctl_q.output_initial_level_select; // see RL1 RL11
    end else if (counter_on_q && a_hit && ctl_q.mode == tmr_pkg::MODE_CMP) begin
      unique case (ctl_q.pin_func)
        tmr_pkg::FN_HOLD: level_d = level_q;
        tmr_pkg::FN_LOW: level_d = 1'b0;
        tmr_pkg::FN_HIGH: level_d = 1'b1;
        tmr_pkg::FN_TOGGLE: level_d = !level_q;
      endcase
    end
    pulse_d = on_rise ? 1'b1 : (counter_on_q && duty_end ? 1'b0 : pulse_q);
    unique case (ctl_q.pin_func)
      tmr_pkg::FN_HOLD: active = 1'b0;
      tmr_pkg::FN_LOW: active = 1'b1;
      tmr_pkg::FN_PWM: active = counter_on_q && duty_act;
      tmr_pkg::FN_PULSE: active = counter_on_q && pulse_q;
    endcase
    // Active level chosen first, inversion applied last
    raw = ctl_q.output_initial_level_select ? active : !active; // see RL2
    drive = 1'b1;
    if (ctl_q.mode == tmr_pkg::MODE_CMP) begin
      raw = level_d;
    end else if (ctl_q.mode != tmr_pkg::MODE_PWM) begin
      raw = 1'b0;
      drive = 1'b0;
    end
    // Timer and capture modes release the pin, so level bits cannot act
    pin_d = drive ? (raw ^ ctl_q.output_invert) : 1'b0; // see RL3 RL4 RL13
    oe_n_d = !drive;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level_q <= 1'b0;
      pulse_q <= 1'b0;
      pin_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      level_q <= level_d;
      pulse_q <= pulse_d;
      pin_q <= pin_d;
      oe_n_q <= oe_n_d;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence seq_cmp_rise;
    on_rise && ctl_q.mode == tmr_pkg::MODE_CMP;
  endsequence

  chk_init_level: assert property (@(posedge clk) disable iff (rst) // see RL1 RL11
    seq_cmp_rise |=> timer_output_pin_o ==
      ($past(ctl_q.output_initial_level_select) ^ $past(ctl_q.output_invert)))
    else $error("compare initial level wrong");
  chk_invert_last: assert property (@(posedge clk) disable iff (rst) // see RL3 RL13
    ctl_q.mode == tmr_pkg::MODE_PWM |=> timer_output_pin_o == ($past(raw) ^ $past(ctl_q.output_invert)))
    else $error("inversion not applied last");
  chk_timer_idle: assert property (@(posedge clk) disable iff (rst) // see RL4
    ctl_q.mode == tmr_pkg::MODE_TMR |=> timer_output_pin_oe_n && !timer_output_pin_o)
    else $error("timer mode touched pin");
  chk_pwm_level: assert property (@(posedge clk) disable iff (rst) // see RL2 RL5
    ctl_q.mode == tmr_pkg::MODE_PWM && ctl_q.pin_func == tmr_pkg::FN_PWM && counter_on_q &&
    !ctl_q.period_duty_swap |=> timer_output_pin_o == ($past(ctl_q.output_invert) ^
      ($past(cnt_q < compare_a_value_q) ? $past(ctl_q.output_initial_level_select)
                                         : !$past(ctl_q.output_initial_level_select))))
    else $error("pwm duty level wrong");
  chk_a_clear: assert property (@(posedge clk) disable iff (rst) // see RL6
    counter_on_q && !on_rise && ctl_q.mode == tmr_pkg::MODE_CMP &&
    ctl_q.clear_source_select && a_hit |=> cnt_q == '0)
    else $error("A match did not clear");
  chk_p_clear: assert property (@(posedge clk) disable iff (rst) // see RL7 RL12
    counter_on_q && !on_rise && ctl_q.mode == tmr_pkg::MODE_TMR &&
    !ctl_q.clear_source_select && compare_p_value_q != 8'h00 &&
    cnt_q[15:8] == compare_p_value_q &&
    cnt_q[7:0] == 8'hff |=> cnt_q == '0)
    else $error("P match did not clear");
  chk_a_ignored: assert property (@(posedge clk) disable iff (rst) // see RL7 RL8
    counter_on_q && !on_rise && ctl_q.mode == tmr_pkg::MODE_CMP &&
    !ctl_q.clear_source_select && a_hit && !p_hit && cnt_q != 16'hffff |=>
    cnt_q == $past(cnt_q) + 16'h0001)
    else $error("A match cleared with select low");
  chk_pwm_no_sel: assert property (@(posedge clk) disable iff (rst) // see RL9
    counter_on_q && !on_rise && ctl_q.mode == tmr_pkg::MODE_PWM && !ctl_q.period_duty_swap &&
    ctl_q.clear_source_select && a_hit && !p_end |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("pwm used clear select");
  chk_reset_zero: assert property (@(posedge clk) disable iff (rst) // see RL14
    $fell(rst) |-> ctl_q == 8'h00)
    else $error("control not zero after reset");
endmodule

// >>> dv/pin_load_model.sv
// External load hanging on the timer output pin
`timescale 1ns/1ps
module pin_load_model (
  // Clock
  input wire logic clk,
  // Pin as the block drives it
  input wire logic pin_o,
  input wire logic pin_oe_n,
  // What the load sees
  output logic pin_level,
  output logic [15:0] rises
);
  logic last_q = 1'b0;
  logic [15:0] count_q = 16'h0000;

  // Released pin falls to the pull-down, it never keeps its last level
  assign pin_level = pin_oe_n ? 1'b0 : pin_o;
  assign rises = count_q;

  always @(posedge clk) begin
    if (pin_level && !last_q) begin
      count_q <= count_q + 16'h0001;
    end
    last_q <= pin_level;
  end
endmodule

// >>> dv/timer_output_and_clear_control_bench.sv
// Self-checking bench for the timer output and clear control block
`timescale 1ns/1ps
module timer_output_and_clear_control_bench;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, pin_o, pin_oe_n, pin_level;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [15:0] rises, top, e0;
  int n_fail, checks_done;

  timer_output_and_clear_control dut (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_output_pin_o(pin_o), .timer_output_pin_oe_n(pin_oe_n));

  pin_load_model load (.clk(clk), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
    .pin_level(pin_level), .rises(rises));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic hang();
    n_fail++;
    $display("wrong value bus answer expected within bound seen none");
    close_out();
  endtask

  // ---------------------------------------------------------------
  // Bus master tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [31:0] v, output logic [1:0] resp);
    bit done;
    done = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) hang();
    // Extra edge so the next request never lands in the same time step
    @(posedge clk);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] resp);
    bit done;
    done = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) hang();
    @(posedge clk);
  endtask

  // Stop, load compares and mode, then restart so the on-bit rises
  task automatic setup(input logic [7:0] mc, input logic [15:0] a, input logic [7:0] p);
    logic [1:0] s;
    wr(tmr_pkg::OFF_RUN_CTRL, 32'h0, s);
    wr(tmr_pkg::OFF_CMP_A, {16'h0, a}, s);
    wr(tmr_pkg::OFF_CMP_P, {24'h0, p}, s);
    wr(tmr_pkg::OFF_MODE_CTRL, {24'h0, mc}, s);
    wr(tmr_pkg::OFF_RUN_CTRL, 32'h1, s);
    chk("write response", s, tmr_pkg::RESP_OKAY);
    repeat (3) @(posedge clk);
  endtask

  // Highest count seen while sampling for about 270 cycles
  task automatic clr_case(input logic [7:0] mc, input logic [15:0] a, input logic [7:0] p,
                          input logic [15:0] lim, input logic [15:0] above);
    setup(mc, a, p);
    top = 16'h0;
    repeat (30) begin
      repeat (6) @(posedge clk);
      rd(tmr_pkg::OFF_COUNT, d, r);
      if (d[15:0] > top) top = d[15:0];
    end
    chk("count ceiling", top <= lim, 1);
    chk("count reach", top > above, 1);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    n_fail = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(tmr_pkg::OFF_MODE_CTRL, d, r);
    chk("mode reset value", d, {24'h0, tmr_pkg::MODE_CTRL_RST});
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      setup({4'h0, i[1:0], 2'b00}, 16'h0100, 8'h00);
      chk("pin compare start", pin_level, i[1] ^ i[0]);
      chk("pin driven in compare", pin_oe_n, 1'b0);
      rd(tmr_pkg::OFF_MODE_CTRL, d, r);
      chk("mode readback", d, {28'h0, i[1:0], 2'b00});
      setup({4'h9, i[1:0], 2'b00}, 16'h0100, 8'h00);
      chk("pin pwm active", pin_level, i[1] ^ i[0]);
      setup({4'h8, i[1:0], 2'b00}, 16'h0100, 8'h00);
      chk("pin pwm inactive", pin_level, !(i[1] ^ i[0]));
      setup({4'hc, i[1:0], 2'b00}, 16'h0100, 8'h00);
      chk("pin timer released", {pin_oe_n, pin_level}, 2'b10);
    end
    $display("test pin levels done");
    // Toggle on the A match, then a restart must bring back the initial level
    setup(8'h30, 16'h0010, 8'h00);
    repeat (20) @(posedge clk);
    chk("pin toggled by A match", pin_level, 1'b1);
    wr(tmr_pkg::OFF_RUN_CTRL, 32'h0, r);
    wr(tmr_pkg::OFF_RUN_CTRL, 32'h1, r);
    repeat (3) @(posedge clk);
    chk("pin restored on restart", pin_level, 1'b0);
    $display("test compare restart done");
    clr_case(8'h01, 16'h0010, 8'h01, 16'h0010, 16'h0008);
    clr_case(8'h00, 16'h0010, 8'h01, 16'h01ff, 16'h00ff);
    clr_case(8'hc0, 16'h0010, 8'h00, 16'hffff, 16'h0100);
    clr_case(8'ha1, 16'h0010, 8'h01, 16'h01ff, 16'h00ff);
    clr_case(8'h41, 16'h0010, 8'h01, 16'h01ff, 16'h0010);
    clr_case(8'ha2, 16'h0020, 8'h01, 16'h0020, 16'h0010);
    $display("test counter clear done");
    setup(8'ha8, 16'h0040, 8'h01);
    e0 = rises;
    repeat (1024) @(posedge clk);
    chk("pwm rising edges", rises - e0, 16'h0002);
    $display("test pwm period done");
    // Single pulse: active from the restart until the duty match, then idle
    setup(8'hb8, 16'h0020, 8'h01);
    chk("pulse active level", pin_level, 1'b1);
    repeat (40) @(posedge clk);
    chk("pulse ended", pin_level, 1'b0);
    $display("test single pulse done");
    rd(5'h14, d, r);
    chk("unmapped read response", r, tmr_pkg::RESP_SLVERR);
    chk("unmapped read data", d, 32'h0);
    wr(tmr_pkg::OFF_COUNT, 32'h1234, r);
    chk("count write response", r, tmr_pkg::RESP_SLVERR);
    $display("test bus errors done");
    close_out();
  end
endmodule
